// ===== cache_test_access_map.svh
// Register offsets, field positions and reset values of the cache test block.
`ifndef CACHE_TEST_ACCESS_MAP_SVH
`define CACHE_TEST_ACCESS_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define CTA_CTL_OFS   32'h0000_0000
`define CTA_STS_OFS   32'h0000_0004
`define CTA_DAT_OFS   32'h0000_0008
`define CTA_MODE_OFS  32'h0000_000C

// ****************************************************************
// Field positions
// ****************************************************************
`define CTA_EXT_BIT   19
`define CTA_SS_HI     18
`define CTA_SS_LO     17
`define CTA_IDX_HI    11
`define CTA_IDX_LO    4
`define CTA_ENT_HI    3
`define CTA_ENT_LO    2
`define CTA_OP_HI     1
`define CTA_TAG_LO    11
`define CTA_VALID_BIT 10

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define CTA_LINE_RST  8'h00
`define CTA_LRU_RST   3'h0
`define CTA_RESP_OK   2'h0
`define CTA_RESP_DEC  2'h3

`endif

// ===== cache_test_access_pkg.sv
// Types shared by the cache test access block.
package cache_test_access_pkg;

    // Test operation codes.
    typedef enum logic [1:0] {
        OP_BUF   = 2'b00,
        OP_CWR   = 2'b01,
        OP_CRD   = 2'b10,
        OP_FLUSH = 2'b11
    } op_type;

    // Line states.
    typedef enum logic [1:0] {
        MESI_INV  = 2'b00,
        MESI_EXCL = 2'b01,
        MESI_MOD  = 2'b10,
        MESI_SHR  = 2'b11
    } mesi_type;

    // AXI4-Lite master to slave.
    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } axil_req_type;

    // AXI4-Lite slave to master.
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } axil_rsp_type;

    // Register state of the block, apart from the cache arrays.
    typedef struct packed {
        logic         strap_done;
        logic         wb_mode;
        logic         ext;
        logic [1:0]   set_state;
        logic [7:0]   index;
        logic [1:0]   entry;
        logic [1:0]   op;
        logic [20:0]  tag;
        logic         valid;
        logic [2:0]   lru;
        logic [3:0]   valids;
        logic [1:0]   selected_set_state;
        logic [7:0]   st;
        logic [127:0] rdbuf;
        logic [127:0] fill;
        logic         aw_full;
        logic [31:0]  awaddr;
        logic         w_full;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        axil_rsp_type rsp;
    } cta_state_type;

endpackage

// ===== cache_test_access.sv
// Cache test access block: test control, status and data over AXI4-Lite.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "cache_test_access_map.svh"
// Contract
// - Field-view bit 19 exists only in write-back mode.
// - View bit 0: status bits 31-11 show the tag.
// - View bit 1: status shows selected state 30-29, way states 27-20.
// - Write-back set state 18-17 encodes invalid, exclusive, modified, shared.
// - Index bits 11-4 pick one of 256 lines, both modes.
// - Entry bits 3-2 pick one of four ways for cache read or write.
// - For buffer access, entry picks one of four doublewords.
// - Operation bits 1-0: buffer, cache write, cache read, flush.
// - Cache read loads tag, set LRU and valids, 128 data bits.
// - With buffer access, data register returns chosen read buffer word.
// - Write-back view bit 1 makes status reads return set states.
// - Data write with buffer access fills the chosen fill buffer word.
// - Write-back cache write ignores valid bit, uses set state field.
// - Status bits 9-0 never affect a cache write.
// - Cache write stores fill buffer and status tag into chosen way.
// - Write-through cache write takes state from the status valid bit.
// - Flush clears every LRU, valid and state bit in both modes.
// - Flush ignores all other fields except view bit in write-back.
// - Reset clears all line states and sets LRU to start state.
// - Policy strap sampled at reset release; high means write-back.
// - Write-back valids are set for exclusive, modified or shared ways.
// - LRU bits read-only, reported on read, changed only by cache write, flush or reset.
module cache_test_access
    import cache_test_access_pkg::*;
(
    // Clock and reset.
    input  wire logic          i_sys_clk,
    input  wire logic          i_rstn,
    // Write-policy strap, high selects write-back.
    input  wire logic          i_write_policy_strap,
    // Register bus.
    input  wire axil_req_type  i_axil,
    output      axil_rsp_type  o_axil,
    // Mode caught from the strap.
    output      logic          o_write_back_mode
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    cta_state_type q;
    cta_state_type d;
    logic [20:0]   tag_mem  [0:1023];
    logic [127:0]  data_mem [0:1023];
    logic [7:0]    st_arr   [0:255];
    logic [2:0]    lru_arr  [0:255];

    logic          ctl_wr;
    logic          cw_en;
    logic          rd_en;
    logic          flush_en;
    logic          fill_en;
    logic [31:0]   wmask;
    logic [31:0]   ctl_view;
    logic [31:0]   sts_view;
    logic [31:0]   ctl_new;
    logic [31:0]   sts_new;
    logic [31:0]   rd_word;
    logic [7:0]    sel_idx;
    logic [1:0]    sel_way;
    logic [1:0]    sel_op;
    logic [9:0]    mem_a;
    logic [1:0]    cw_state;
    logic [7:0]    rd_st;
    logic [3:0]    rd_valid;
    logic [2:0]    lru_old;
    logic [2:0]    lru_next;

    // Byte-lane merge for partial writes.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        return (old_v & ~m) | (new_v & m);
    endfunction

    // Outputs come straight from the state flops.
    assign o_axil            = q.rsp;
    assign o_write_back_mode = q.wb_mode;

    // ****************************************************************
    // Register views
    // ****************************************************************
    // Control view; ext and set state are held at zero in write-through.
    assign ctl_view = {12'h000, q.ext, q.set_state, 5'h00,
                       q.index, q.entry, q.op};

    // Status view: set states when ext is on in write-back, else the tag.
    always_comb begin
        if (q.wb_mode && q.ext) begin
            sts_view = {1'b0, q.selected_set_state, 1'b0, q.st, 9'h000,
                        q.valid, q.lru, q.valids, 3'h0};
        end else begin
            sts_view = {q.tag, q.valid, q.lru, q.valids, 3'h0};
        end
    end

    // Pending write data and its byte mask.
    assign wmask   = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}},
                      {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
    assign ctl_new = merge(ctl_view, q.wdata, wmask);
    assign sts_new = merge(sts_view, q.wdata, wmask);

    // Line and way chosen by the control word being written.
    assign sel_idx = ctl_new[`CTA_IDX_HI:`CTA_IDX_LO];
    assign sel_way = ctl_new[`CTA_ENT_HI:`CTA_ENT_LO];
    assign sel_op  = ctl_new[`CTA_OP_HI:0];
    assign mem_a   = {sel_idx, sel_way};

    // ****************************************************************
    // Set lookup
    // ****************************************************************
    assign rd_st   = st_arr[sel_idx];
    assign lru_old = lru_arr[sel_idx];

    // A way counts as valid in any state other than invalid.
    for (genvar w = 0; w < 4; w++) begin : g_valid
        assign rd_valid[w] = (rd_st[2*w +: 2] != MESI_INV);
    end

    // Pseudo-LRU tree after touching the written way.
    assign lru_next = {sel_way[1] ? ~sel_way[0] : lru_old[2],
                       sel_way[1] ? lru_old[1] : ~sel_way[0],
                       ~sel_way[1]};

    // New line state: write-back takes the set state field, write-through
    // the status valid bit; the LRU and valid-list bits play no part.
    assign cw_state = q.wb_mode
                    ? ctl_new[`CTA_SS_HI:`CTA_SS_LO]
                    : (q.valid ? MESI_EXCL : MESI_INV);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d        = q;
        ctl_wr   = 1'b0;
        cw_en    = 1'b0;
        rd_en    = 1'b0;
        flush_en = 1'b0;
        fill_en  = 1'b0;
        rd_word  = 32'h0000_0000;

        // Catch the strap on the first edge after reset lets go.
        if (!q.strap_done) begin
            d.strap_done = 1'b1;
            d.wb_mode    = i_write_policy_strap;
        end

        // Address and data are taken independently, in either order.
        if (i_axil.awvalid && q.rsp.awready) begin
            d.aw_full = 1'b1;
            d.awaddr  = i_axil.awaddr;
        end
        if (i_axil.wvalid && q.rsp.wready) begin
            d.w_full = 1'b1;
            d.wdata  = i_axil.wdata;
            d.wstrb  = i_axil.wstrb;
        end
        if (q.rsp.bvalid && i_axil.bready) begin
            d.rsp.bvalid = 1'b0;
        end

        // Perform the write once both halves are held.
        if (q.aw_full && q.w_full && !q.rsp.bvalid) begin
            d.aw_full    = 1'b0;
            d.w_full     = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp  = `CTA_RESP_OK;
            unique case (q.awaddr)
                `CTA_CTL_OFS: begin
                    ctl_wr = 1'b1;
                    d.op   = sel_op;
                    if (q.wb_mode) begin
                        d.ext = ctl_new[`CTA_EXT_BIT];
                    end
                    if (sel_op != OP_FLUSH) begin
                        d.index = sel_idx;
                        d.entry = sel_way;
                        if (q.wb_mode) begin
                            d.set_state = ctl_new[`CTA_SS_HI:`CTA_SS_LO];
                        end
                    end
                    // Buffer access only latches the fields.
                    unique case (sel_op)
                        OP_BUF:   ;
                        OP_CWR:   cw_en    = 1'b1;
                        OP_CRD:   rd_en    = 1'b1;
                        OP_FLUSH: flush_en = 1'b1;
                    endcase
                end
                `CTA_STS_OFS: begin
                    // Only the tag and valid bit are writable here.
                    if (!(q.wb_mode && q.ext)) begin
                        d.tag = sts_new[31:`CTA_TAG_LO];
                    end
                    d.valid = sts_new[`CTA_VALID_BIT];
                end
                `CTA_DAT_OFS: begin
                    if (q.op == OP_BUF) begin
                        fill_en = 1'b1;
                        d.fill[{q.entry, 5'h00} +: 32] =
                            merge(q.fill[{q.entry, 5'h00} +: 32],
                                  q.wdata, wmask);
                    end
                end
                `CTA_MODE_OFS: ;
                default: d.rsp.bresp = `CTA_RESP_DEC;
            endcase
        end

        // Cache read fills the status fields and the read buffer.
        if (rd_en) begin
            d.tag    = tag_mem[mem_a];
            d.st     = rd_st;
            d.selected_set_state    = rd_st[{sel_way, 1'b0} +: 2];
            d.lru    = lru_old;
            d.valids = rd_valid;
            d.valid  = rd_valid[sel_way];
            d.rdbuf  = data_mem[mem_a];
        end

        // Reads answer one cycle after the address is taken.
        if (q.rsp.rvalid && i_axil.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        if (i_axil.arvalid && q.rsp.arready) begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rresp  = `CTA_RESP_OK;
            unique case (i_axil.araddr)
                `CTA_CTL_OFS:  rd_word = ctl_view;
                `CTA_STS_OFS:  rd_word = sts_view;
                `CTA_DAT_OFS: begin
                    if (q.op == OP_BUF) begin
                        rd_word = q.rdbuf[{q.entry, 5'h00} +: 32];
                    end
                end
                `CTA_MODE_OFS: rd_word = {31'h0000_0000, q.wb_mode};
                default:       d.rsp.rresp = `CTA_RESP_DEC;
            endcase
            d.rsp.rdata = rd_word;
        end

        // Ready only while the matching holding slot is free.
        d.rsp.awready = !d.aw_full;
        d.rsp.wready  = !d.w_full;
        d.rsp.arready = !d.rsp.rvalid;
    end

    // State register; ready outputs rise one edge after reset release.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Cache array
    // ****************************************************************
    // Line states and LRU trees need a reset and a one-edge flush, so
    // they stay in flops; tag and data are plain memories.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < 256; i++) begin
                st_arr[i]  <= `CTA_LINE_RST;
                lru_arr[i] <= `CTA_LRU_RST;
            end
        end else if (flush_en) begin
            for (int i = 0; i < 256; i++) begin
                st_arr[i]  <= `CTA_LINE_RST;
                lru_arr[i] <= `CTA_LRU_RST;
            end
        end else if (cw_en) begin
            st_arr[sel_idx][{sel_way, 1'b0} +: 2] <= cw_state;
            lru_arr[sel_idx] <= lru_next;
        end
    end

    // Tag and line data of the written way.
    always_ff @(posedge i_sys_clk) begin
        if (cw_en) begin
            tag_mem[mem_a]  <= q.tag;
            data_mem[mem_a] <= q.fill;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_cache_rd;
        rd_en && (sel_op == OP_CRD);
    endsequence

    sequence s_sts_read;
        i_axil.arvalid && q.rsp.arready
            && (i_axil.araddr == `CTA_STS_OFS);
    endsequence

    property p_ext_wt;
        q.strap_done && !q.wb_mode |-> !q.ext && (q.set_state == 2'b00);
    endproperty
    a_ext_wt: assert property (p_ext_wt)
        else $error("ext bit set in write-through mode");

    property p_tag_view;
        s_sts_read ##0 !(q.wb_mode && q.ext)
            |=> q.rsp.rdata[31:11] == $past(q.tag);
    endproperty
    a_tag_view: assert property (p_tag_view)
        else $error("status read did not show the tag");

    property p_state_view;
        s_sts_read ##0 (q.wb_mode && q.ext)
            |=> (q.rsp.rdata[30:29] == $past(q.selected_set_state))
                && (q.rsp.rdata[27:20] == $past(q.st));
    endproperty
    a_state_view: assert property (p_state_view)
        else $error("status read did not show set states");

    property p_read_load;
        s_cache_rd |=> (q.lru == lru_arr[q.index])
            && (q.tag == tag_mem[{q.index, q.entry}]);
    endproperty
    a_read_load: assert property (p_read_load)
        else $error("cache read did not load status");

    property p_fill;
        fill_en && (q.wstrb == 4'hF)
            |=> q.fill[{$past(q.entry), 5'h00} +: 32] == $past(q.wdata);
    endproperty
    a_fill: assert property (p_fill)
        else $error("fill buffer word not written");

    property p_cw_tag;
        cw_en |=> tag_mem[{$past(sel_idx), $past(sel_way)}] == $past(q.tag);
    endproperty
    a_cw_tag: assert property (p_cw_tag)
        else $error("cache write lost the tag");

    property p_cw_wt;
        cw_en && !q.wb_mode |=> st_arr[$past(sel_idx)]
            [{$past(sel_way), 1'b0} +: 2] == ($past(q.valid) ? 2'b01 : 2'b00);
    endproperty
    a_cw_wt: assert property (p_cw_wt)
        else $error("write-through state not from valid bit");

    property p_flush;
        flush_en |=> (st_arr[q.index] == 8'h00) && (lru_arr[q.index] == 3'h0)
            && (q.index == $past(q.index));
    endproperty
    a_flush: assert property (p_flush)
        else $error("flush left state behind");

    // The addressed set must come through a buffer setup untouched.
    property p_buf_safe;
        ctl_wr && (sel_op == OP_BUF)
            |=> (st_arr[$past(sel_idx)] == $past(rd_st))
                && (lru_arr[$past(sel_idx)] == $past(lru_old));
    endproperty
    a_buf_safe: assert property (p_buf_safe)
        else $error("buffer access touched the array");

    // Keyed on the capture flag, so the edge at which reset lets go
    // cannot start an attempt against the cleared mode flop.
    property p_strap;
        $rose(q.strap_done) |-> q.wb_mode == $past(i_write_policy_strap);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap not caught");

endmodule

// ===== cache_test_access_bench.sv
// Self-checking bench for the cache test access block over AXI4-Lite.
`timescale 1ns/1ps
`include "cache_test_access_map.svh"
module cache_test_access_bench
    import cache_test_access_pkg::*;
;
    // ****************************************************************
    // Clock, reset and design connections
    // ****************************************************************
    logic         sys_clk = 1'h0;
    logic         rstn;
    logic         strap;
    axil_req_type req;
    axil_rsp_type rsp;
    logic         wb_mode;
    int           n_errors = 0;
    int           n_compared = 0;
    logic [31:0]  rdata;
    logic [1:0]   resp;
    logic [20:0]  tag_a = 21'h15_A5C3;
    logic [20:0]  tag_b = 21'h0A_5A3C;
    logic [20:0]  tag_c = 21'h1F_0F0F;

    // The clock toggles every half period of 5 ns.
    always #5 sys_clk = ~sys_clk;

    cache_test_access u_cache_test_access (
        .i_sys_clk            (sys_clk),
        .i_rstn               (rstn),
        .i_write_policy_strap (strap),
        .i_axil               (req),
        .o_axil               (rsp),
        .o_write_back_mode    (wb_mode)
    );

    // ****************************************************************
    // Bus tasks and helpers
    // ****************************************************************
    // Compares one value and counts the outcome.
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask

    // One write; the leading edge keeps two transfers from touching the
    // same strobe within one time step.
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bit done;
        done = 1'h0;
        @(posedge sys_clk);
        req.awvalid <= 1'h1;
        req.awaddr  <= a;
        req.wvalid  <= 1'h1;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.bready  <= 1'h1;
        while (!done) begin
            @(posedge sys_clk);
            if (req.awvalid && rsp.awready) begin
                req.awvalid <= 1'h0;
            end
            if (req.wvalid && rsp.wready) begin
                req.wvalid <= 1'h0;
            end
            if (req.bready && rsp.bvalid) begin
                req.bready <= 1'h0;
                resp = rsp.bresp;
                done = 1'h1;
            end
        end
    endtask

    // One read; rready stays high until rvalid is sampled.
    task automatic rd(input logic [31:0] a);
        bit done;
        done = 1'h0;
        @(posedge sys_clk);
        req.arvalid <= 1'h1;
        req.araddr  <= a;
        req.rready  <= 1'h1;
        while (!done) begin
            @(posedge sys_clk);
            if (req.arvalid && rsp.arready) begin
                req.arvalid <= 1'h0;
            end
            if (req.rready && rsp.rvalid) begin
                req.rready <= 1'h0;
                rdata = rsp.rdata;
                resp = rsp.rresp;
                done = 1'h1;
            end
        end
    endtask

    // Reads a register and compares it with the expected word.
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp,
                          input string name);
        rd(a);
        check(name, rdata, exp);
    endtask

    // Packs the control register fields.
    function automatic logic [31:0] ctl(input logic e, input logic [1:0] ss,
        input logic [7:0] idx, input logic [1:0] ent, input logic [1:0] op);
        return {12'h000, e, ss, 5'h00, idx, ent, op};
    endfunction

    // Fill pattern for one doubleword of a line.
    function automatic logic [31:0] fw(input logic [1:0] k);
        return 32'h3C3C_5A00 | {30'h0000_0000, k};
    endfunction

    // Strap is set up before release so it is caught as reset ends.
    task automatic do_reset(input logic s);
        @(posedge sys_clk);
        rstn  <= 1'h0;
        strap <= s;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'h1;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic summarize();
        $display("Compared %0d values, %0d mismatches", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    // Write-back mode first, then a second reset into write-through.
    initial begin
        req   = '0;
        rstn  = 1'h0;
        strap = 1'h1;
        do_reset(1'h1);
        rd_chk(`CTA_MODE_OFS, 32'h0000_0001, "mode reg");
        check("mode pin", {31'h0000_0000, wb_mode}, 32'h0000_0001);
        rd(32'h0000_0010);
        check("unmapped resp", {30'h0000_0000, resp}, 32'h0000_0003);
        wr(32'h0000_0010, 32'h0000_0000);
        check("unmapped wresp", {30'h0000_0000, resp}, 32'h0000_0003);
        // Fill the line buffer while a stale set state rides along.
        for (int k = 0; k < 4; k++) begin
            wr(`CTA_CTL_OFS, ctl(1'h0, MESI_SHR, 8'h5A, k[1:0], OP_BUF));
            wr(`CTA_DAT_OFS, fw(k[1:0]));
        end
        // Valid bit clear and low bits set: both must be ignored here.
        wr(`CTA_STS_OFS, {tag_a, 1'h0, 10'h3FF});
        wr(`CTA_CTL_OFS, ctl(1'h0, MESI_MOD, 8'h5A, 2'h2, OP_CWR));
        wr(`CTA_CTL_OFS, ctl(1'h0, MESI_INV, 8'h5A, 2'h2, OP_CRD));
        rd_chk(`CTA_STS_OFS, {tag_a, 1'h1, 3'h4, 4'h4, 3'h0}, "wb status");
        for (int k = 0; k < 4; k++) begin
            wr(`CTA_CTL_OFS, ctl(1'h0, MESI_SHR, 8'h5A, k[1:0], OP_BUF));
            rd_chk(`CTA_DAT_OFS, fw(k[1:0]), "read buffer");
        end
        wr(`CTA_CTL_OFS, ctl(1'h1, MESI_INV, 8'h5A, 2'h2, OP_CRD));
        rd_chk(`CTA_STS_OFS, {1'h0, 2'h2, 1'h0, 8'h20, 9'h000, 1'h1, 3'h4,
               4'h4, 3'h0}, "state view");
        // Flush with other fields changed: only op and view bit may move.
        wr(`CTA_CTL_OFS, ctl(1'h1, MESI_EXCL, 8'h11, 2'h1, OP_FLUSH));
        rd_chk(`CTA_CTL_OFS, ctl(1'h1, MESI_INV, 8'h5A, 2'h2, OP_FLUSH),
               "flush ctl");
        wr(`CTA_CTL_OFS, ctl(1'h0, MESI_INV, 8'h5A, 2'h2, OP_CRD));
        rd(`CTA_STS_OFS);
        check("flush state", rdata & 32'h0000_07FF, 32'h0000_0000);
        // Leave a live way behind so the next reset has state to clear.
        wr(`CTA_CTL_OFS, ctl(1'h0, MESI_EXCL, 8'h03, 2'h1, OP_CWR));
        $display("Write-back tests done");
        do_reset(1'h0);
        rd_chk(`CTA_MODE_OFS, 32'h0000_0000, "mode reg");
        check("mode pin", {31'h0000_0000, wb_mode}, 32'h0000_0000);
        wr(`CTA_CTL_OFS, ctl(1'h0, MESI_INV, 8'h03, 2'h1, OP_CRD));
        rd_chk(`CTA_STS_OFS, {tag_a, 11'h000}, "reset state");
        // The view bit and set state must not stick in this mode.
        wr(`CTA_CTL_OFS, ctl(1'h1, MESI_SHR, 8'h03, 2'h1, OP_BUF));
        rd_chk(`CTA_CTL_OFS, ctl(1'h0, MESI_INV, 8'h03, 2'h1, OP_BUF),
               "wt ctl");
        wr(`CTA_STS_OFS, {tag_b, 1'h1, 10'h000});
        wr(`CTA_CTL_OFS, ctl(1'h0, MESI_INV, 8'h03, 2'h1, OP_CWR));
        wr(`CTA_STS_OFS, {tag_c, 1'h0, 10'h3FF});
        wr(`CTA_CTL_OFS, ctl(1'h0, MESI_MOD, 8'h03, 2'h0, OP_CWR));
        wr(`CTA_CTL_OFS, ctl(1'h0, MESI_INV, 8'h03, 2'h1, OP_CRD));
        rd_chk(`CTA_STS_OFS, {tag_b, 1'h1, 3'h3, 4'h2, 3'h0}, "wt way1");
        wr(`CTA_CTL_OFS, ctl(1'h0, MESI_INV, 8'h03, 2'h0, OP_CRD));
        rd_chk(`CTA_STS_OFS, {tag_c, 1'h0, 3'h3, 4'h2, 3'h0}, "wt way0");
        $display("Write-through tests done");
        summarize();
    end

    // A hang is cut short well beyond the under two hundred cycles needed.
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        summarize();
    end

endmodule
